// ---- hdl/serial_setup_defines.svh ----
`ifndef SERIAL_SETUP_DEFINES_SVH
`define SERIAL_SETUP_DEFINES_SVH

// Clock rate and baud divisors (clk cycles per bit)
`define CLK_HZ 100000000
`define BAUD_4800 4800
`define BAUD_9600 9600
`define BAUD_19200 19200
`define BAUD_38400 38400
`define DIV_W 16
`define DIVISOR(b) (((`CLK_HZ) + (b) / 2) / (b))
// Baud selector codes: 2'b00 all switches off
`define BSEL_OFF 2'h0
`define BSEL_9600 2'h1
`define BSEL_19200 2'h2
`define BSEL_38400 2'h3
// Frame layout: N-8-1
`define DATA_BITS 8
`define BIT_CNT_W 4
// Unit identification
`define UNIT_ID_W 4
`define UNIT_ID_DEFAULT 4'h1
`define UNIT_ID_MIN 4'h1
`define UNIT_ID_MAX 4'h9
// Axis card identification
`define AXIS_ID_W 3
`define AXIS_ID_MIN 3'h1
`define AXIS_ID_MAX 3'h4
`define AXIS_CARDS 4

`endif

// ---- hdl/serial_setup_pkg.sv ----
package serial_setup_pkg;
  `include "serial_setup_defines.svh"

  typedef enum logic [3:0] {
    TX_IDLE = 4'b0001,
    TX_START = 4'b0010,
    TX_DATA = 4'b0100,
    TX_STOP = 4'b1000
  } tx_state_t;

  typedef logic [`DIV_W-1:0] divisor_t;
endpackage

// ---- hdl/byte_stream_if.sv ----
// Byte stream with valid/ready into a transmitter, from the host buffer or straight from the aux inputs
interface byte_stream_if;
  logic valid;
  logic ready;
  logic [7:0] data;
  modport source (output valid, output data, input ready);
  modport sink (input valid, input data, output ready);
endinterface

// ---- hdl/n81_tx.sv ----
// N-8-1 transmitter: start bit, eight data bits LSB first, one stop bit
module n81_tx
  import serial_setup_pkg::*;
(
  input wire logic clk, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire divisor_t divisor, // Clocks per bit
  byte_stream_if.sink in, // Words to send
  output logic txd // Serial line, idles high
);
  typedef struct packed {
    tx_state_t state;
    divisor_t cnt;
    logic [`BIT_CNT_W-1:0] bitIdx;
    logic [7:0] shift;
    logic txd;
  } tx_reg_t;

  tx_reg_t cur;
  tx_reg_t next_cur;

  assign in.ready = (cur.state == TX_IDLE);
  assign txd = cur.txd;

  // Bit timer and framing; no parity bit is ever inserted
  always_comb
  begin
    next_cur = cur;
    case (cur.state)
      TX_IDLE:
      begin
        next_cur.txd = 1'b1;
        if (in.valid)
        begin
          next_cur.shift = in.data;
          next_cur.cnt = divisor - divisor_t'(1);
          next_cur.txd = 1'b0;
          next_cur.state = TX_START;
        end
      end
      TX_START, TX_DATA:
      begin
        if (cur.cnt == '0)
        begin
          next_cur.cnt = divisor - divisor_t'(1);
          if (cur.state == TX_START)
          begin
            next_cur.bitIdx = '0;
            next_cur.state = TX_DATA;
            next_cur.txd = cur.shift[0];
          end
          else if (cur.bitIdx == `BIT_CNT_W'(`DATA_BITS - 1))
          begin
            next_cur.txd = 1'b1; // Single stop bit
            next_cur.state = TX_STOP;
          end
          else
          begin
            next_cur.shift = {1'b0, cur.shift[7:1]};
            next_cur.bitIdx = cur.bitIdx + `BIT_CNT_W'(1);
            next_cur.txd = cur.shift[1];
          end
        end
        else
          next_cur.cnt = cur.cnt - divisor_t'(1);
      end
      TX_STOP:
      begin
        if (cur.cnt == '0)
          next_cur.state = TX_IDLE;
        else
          next_cur.cnt = cur.cnt - divisor_t'(1);
      end
      default:
        next_cur.state = TX_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cur.state <= TX_IDLE;
      cur.cnt <= '0;
      cur.bitIdx <= '0;
      cur.shift <= '0;
      cur.txd <= 1'b1;
    end
    else
      cur <= next_cur;
  end
endmodule

// ---- hdl/serial_port_setup_select.sv ----
// Functional notes
// - Host baud selector sampled once at power-up; later changes ignored.
// - Selector decodes 9600, 19200, 38400; all switches off gives 4800.
// - Shipped selector setting yields 9600 baud on the host port.
// - Host port frames are no parity, eight data, one stop bit.
// - Auxiliary port frames are also no parity, eight data, one stop.
// - Auxiliary port runs 9600 by default; port-setting command changes it.
// - Host electrical standard select; single-ended is the shipped default.
// - Auxiliary electrical standard by jumper; differential multidrop by default.
// - Unit ID captured at power-up and on each system reset command.
// - Shipped unit ID selector presents one, the first chain unit.
// - All motion inhibited unless the motion-clear input is asserted.
module serial_port_setup_select
  import serial_setup_pkg::*;
(
  input wire logic clk, // 100 MHz system clock
  input wire logic rst_n, // Power-up reset, synchronous, active low
  input wire logic [1:0] baudSelect, // Host baud switches, 00 = all off
  input wire logic hostDiffSelect, // 1 = differential multidrop on host port
  input wire logic auxSingleEndedJumper, // 1 = single-ended on aux port
  input wire logic [`UNIT_ID_W-1:0] unitIdSwitch, // Unit ID selector
  input wire logic systemResetCmd, // Pulse: system reset command received
  input wire logic portSettingCommand, // Pulse: load new aux rate
  input wire logic [1:0] portSettingRate, // Rate code for the aux port
  input wire logic motion_clear_input, // High when tied to its return
  input wire logic [`AXIS_CARDS*`AXIS_ID_W-1:0] axisCardIds, // Card IDs, 0 = absent
  input wire logic hostTxValid, // Host-port word offered
  input wire logic [7:0] hostTxData, // Host-port word
  output logic hostTxReady, // Buffer can take a word
  input wire logic auxTxValid, // Aux-port word offered
  input wire logic [7:0] auxTxData, // Aux-port word
  output logic auxTxReady, // Aux port can take a word
  output logic hostTxd, // Host serial line out
  output logic auxTxd, // Aux serial line out
  output logic [`DIV_W-1:0] hostDivisor, // Host clocks per bit
  output logic [`DIV_W-1:0] auxDivisor, // Aux clocks per bit
  output logic hostDiffMode, // Host driver in differential mode
  output logic auxDiffMode, // Aux driver in differential mode
  output logic [`UNIT_ID_W-1:0] unitId, // Captured unit ID
  output logic unitIdValid, // Captured ID lies in 1..9
  output logic axisIdsValid, // Card IDs distinct, none above four, and one present
  output logic motionEnable // Motion permitted
);
  // Captured configuration, buffer entry count and storage kept as one state struct
  typedef struct packed {
    logic sampled;
    divisor_t hostDiv;
    divisor_t auxDiv;
    logic hostDiff;
    logic auxDiff;
    logic [`UNIT_ID_W-1:0] unitId;
    logic [1:0] bufCount;
    logic bufHead;
    logic [1:0][7:0] bufMem;
    logic motionEnable;
    logic axisOk;
  } top_reg_t;

  top_reg_t cur;
  top_reg_t next_cur;
  logic bufPush;
  logic bufPop;
  logic [`AXIS_CARDS-1:0] idOne;
  logic [`AXIS_CARDS-1:0] idClash;

  byte_stream_if hostStream();
  byte_stream_if auxStream();

  // Rate code to divisor, shared by host switches and aux command
  function automatic divisor_t rate_divisor(input logic [1:0] code);
    case (code)
      `BSEL_9600: rate_divisor = divisor_t'(`DIVISOR(`BAUD_9600));
      `BSEL_19200: rate_divisor = divisor_t'(`DIVISOR(`BAUD_19200));
      `BSEL_38400: rate_divisor = divisor_t'(`DIVISOR(`BAUD_38400));
      default: rate_divisor = divisor_t'(`DIVISOR(`BAUD_4800));
    endcase
  endfunction

  // Per-card checks: each slot compared with every other one
  genvar gi;
  generate
    for (gi = 0; gi < `AXIS_CARDS; gi++)
    begin : g_card
      logic [`AXIS_ID_W-1:0] myId;
      logic [`AXIS_CARDS-1:0] clash;
      assign myId = axisCardIds[gi*`AXIS_ID_W +: `AXIS_ID_W];
      assign idOne[gi] = (myId == `AXIS_ID_MIN);
      for (genvar gj = 0; gj < `AXIS_CARDS; gj++)
      begin : g_peer
        // Absent cards (ID 0) never clash; out-of-range IDs always flag
        assign clash[gj] = (gj != gi) && (myId != '0)
          && (myId == axisCardIds[gj*`AXIS_ID_W +: `AXIS_ID_W]);
      end
      assign idClash[gi] = (|clash) || (myId > `AXIS_ID_MAX);
    end
  endgenerate

  // Two-entry buffer in the host transmit path
  assign hostTxReady = (cur.bufCount != 2'h2);
  assign bufPush = hostTxValid && hostTxReady;
  assign bufPop = hostStream.valid && hostStream.ready;
  assign hostStream.valid = (cur.bufCount != 2'h0);
  assign hostStream.data = cur.bufMem[cur.bufHead];

  // Aux words pass straight to its transmitter
  assign auxStream.valid = auxTxValid;
  assign auxStream.data = auxTxData;
  assign auxTxReady = auxStream.ready;

  // Next state for configuration capture and buffer
  always_comb
  begin
    next_cur = cur;
    if (!cur.sampled)
    begin
      next_cur.sampled = 1'b1;
      next_cur.hostDiv = rate_divisor(baudSelect);
      next_cur.hostDiff = hostDiffSelect;
      next_cur.auxDiff = !auxSingleEndedJumper;
      next_cur.unitId = unitIdSwitch;
    end
    else if (systemResetCmd)
      next_cur.unitId = unitIdSwitch;
    if (portSettingCommand)
      next_cur.auxDiv = rate_divisor(portSettingRate);
    if (bufPush)
      next_cur.bufMem[cur.bufHead ^ cur.bufCount[0]] = hostTxData;
    if (bufPop)
      next_cur.bufHead = !cur.bufHead;
    case ({bufPush, bufPop})
      2'b10: next_cur.bufCount = cur.bufCount + 2'h1;
      2'b01: next_cur.bufCount = cur.bufCount - 2'h1;
      default: next_cur.bufCount = cur.bufCount;
    endcase
    next_cur.axisOk = (|idOne) && !(|idClash);
    next_cur.motionEnable = motion_clear_input;
  end

  // Reset loads shipped defaults; straps are caught the cycle after release
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      cur.sampled <= 1'b0;
      cur.hostDiv <= divisor_t'(`DIVISOR(`BAUD_9600));
      cur.auxDiv <= divisor_t'(`DIVISOR(`BAUD_9600));
      cur.hostDiff <= 1'b0;
      cur.auxDiff <= 1'b1;
      cur.unitId <= `UNIT_ID_DEFAULT;
      cur.bufCount <= 2'h0;
      cur.bufHead <= 1'b0;
      cur.bufMem <= '0;
      cur.motionEnable <= 1'b0;
      cur.axisOk <= 1'b0;
    end
    else
      cur <= next_cur;
  end

  // Host transmitter only runs once the rate has been latched
  n81_tx hostTx (
    .clk(clk),
    .rst_n(rst_n),
    .divisor(cur.hostDiv),
    .in(hostStream),
    .txd(hostTxd)
  );

  // Aux transmitter
  n81_tx auxTx (
    .clk(clk),
    .rst_n(rst_n),
    .divisor(cur.auxDiv),
    .in(auxStream),
    .txd(auxTxd)
  );

  assign hostDivisor = cur.hostDiv;
  assign auxDivisor = cur.auxDiv;
  assign hostDiffMode = cur.hostDiff;
  assign auxDiffMode = cur.auxDiff;
  assign unitId = cur.unitId;
  // Chain IDs outside 1..9 are flagged for the host to fix
  assign unitIdValid = (cur.unitId >= `UNIT_ID_MIN) && (cur.unitId <= `UNIT_ID_MAX);
  assign axisIdsValid = cur.axisOk;
  assign motionEnable = cur.motionEnable;
endmodule

// ---- dv/n81_line_monitor.sv ----
module n81_line_monitor
(
  input wire logic clk, // System clock
  input wire logic rxd, // Line watched
  input wire logic [15:0] bitTime // Clocks per bit
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] q[$];
  logic [7:0] sr;
  int frameErr = 0;
  // Mid-cell sampling; a short start or a low stop bit is a framing fault
  initial
    forever
    begin
      @(negedge rxd);
      repeat (bitTime / 2) @(posedge clk);
      if (rxd !== 1'b0) frameErr++;
      for (int i = 0; i < 8; i++)
      begin
        repeat (bitTime) @(posedge clk);
        sr[i] = rxd;
      end
      repeat (bitTime) @(posedge clk);
      if (rxd !== 1'b1) frameErr++;
      q.push_back(sr);
    end
endmodule

// ---- dv/serial_port_setup_select_sva.sv ----
module serial_port_setup_select_sva
  import serial_setup_pkg::*;
(
  input wire logic clk, // Clock
  input wire logic rst_n, // Reset
  input wire logic [1:0] baudSelect, // Rate straps
  input wire logic hostDiffSelect, // Host strap
  input wire logic auxSingleEndedJumper, // Aux jumper
  input wire logic [3:0] unitIdSwitch, // ID selector
  input wire logic systemResetCmd, // ID recapture
  input wire logic portSettingCommand, // Aux rate load
  input wire logic [1:0] portSettingRate, // Aux rate code
  input wire logic motion_clear_input, // Clear input
  input wire logic auxTxValid, // Aux offer
  input wire logic auxTxReady, // Aux accept
  input wire logic auxTxd, // Aux line
  input wire logic [15:0] hostDivisor, // Host bit time
  input wire logic [15:0] auxDivisor, // Aux bit time
  input wire logic hostDiffMode, // Host mode
  input wire logic auxDiffMode, // Aux mode
  input wire logic [3:0] unitId, // Captured ID
  input wire logic unitIdValid, // ID in range
  input wire logic motionEnable // Motion allowed
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Rounded clocks per bit for a rate code
  function automatic logic [15:0] divOf(input logic [1:0] c);
    return 16'((100000000 + (2400 << c)) / (4800 << c));
  endfunction
  sequence afterRst; $past(rst_n) && !$past(rst_n, 2); endsequence
  sequence auxTake; auxTxValid && auxTxReady; endsequence
  // Straps land on the first edge after release and then freeze until the next reset
  host_rate_a: assert property (afterRst |-> hostDivisor == divOf($past(baudSelect)))
    else $error("host rate");
  strap_hold_a: assert property ($past(rst_n) && $past(rst_n, 2)
    |-> $stable({hostDivisor, hostDiffMode, auxDiffMode})) else $error("strap moved");
  drv_mode_a: assert property (afterRst |-> hostDiffMode == $past(hostDiffSelect)
    && auxDiffMode == !$past(auxSingleEndedJumper)) else $error("driver mode");
  motion_gate_a: assert property ($past(rst_n) |-> motionEnable == $past(motion_clear_input))
    else $error("motion gate");
  id_capture_a: assert property (systemResetCmd |=> unitId == $past(unitIdSwitch))
    else $error("id capture");
  id_hold_a: assert property ($past(rst_n) && $past(rst_n, 2) && !$past(systemResetCmd)
    |-> $stable(unitId)) else $error("id moved");
  id_range_a: assert property (unitIdValid == (unitId >= 4'h1 && unitId <= 4'h9)) else $error("id range");
  aux_rate_a: assert property (portSettingCommand |=> auxDivisor == divOf($past(portSettingRate)))
    else $error("aux rate");
  aux_start_a: assert property (auxTake |=> ##[0:1] !auxTxd ##1 !auxTxd && !auxTxReady)
    else $error("aux start");
endmodule
bind serial_port_setup_select serial_port_setup_select_sva sva (.clk, .rst_n, .baudSelect, .hostDiffSelect,
  .auxSingleEndedJumper, .unitIdSwitch, .systemResetCmd, .portSettingCommand, .portSettingRate, .motion_clear_input,
  .auxTxValid, .auxTxReady, .auxTxd, .hostDivisor, .auxDivisor, .hostDiffMode, .auxDiffMode, .unitId, .unitIdValid,
  .motionEnable);

// ---- dv/serial_port_setup_select_tb_top.sv ----
module serial_port_setup_select_tb_top
  import serial_setup_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
`define CHK(a, e) begin checkCount++; if ((a) !== (e)) \
  begin errorCnt++; $display("ERROR %0t: got %h want %h", $time, a, e); end end
  logic clk, rst_n, hostDiffSelect, auxSingleEndedJumper, systemResetCmd, portSettingCommand;
  logic motion_clear_input, hostTxValid, auxTxValid, hostTxReady, auxTxReady, hostTxd, auxTxd;
  logic hostDiffMode, auxDiffMode, unitIdValid, axisIdsValid, motionEnable;
  logic [1:0] baudSelect, portSettingRate;
  logic [3:0] unitIdSwitch, unitId;
  logic [7:0] hostTxData, auxTxData, d;
  logic [11:0] axisCardIds;
  logic [15:0] hostDivisor, auxDivisor;
  logic [7:0] hostExp[$], auxExp[$];
  // First three sets are legal, the rest hold a duplicate, no ID one, or an ID above four
  logic [11:0] axisCase[6] = '{12'h001, 12'h00a, 12'h8d1, 12'h009, 12'h01a, 12'h029};
  int errorCnt = 0, checkCount = 0, cycles = 0, seed = 56886;

  serial_port_setup_select DUT (.clk, .rst_n, .baudSelect, .hostDiffSelect, .auxSingleEndedJumper, .unitIdSwitch,
    .systemResetCmd, .portSettingCommand, .portSettingRate, .motion_clear_input, .axisCardIds, .hostTxValid,
    .hostTxData, .hostTxReady, .auxTxValid, .auxTxData, .auxTxReady, .hostTxd, .auxTxd, .hostDivisor, .auxDivisor,
    .hostDiffMode, .auxDiffMode, .unitId, .unitIdValid, .axisIdsValid, .motionEnable);
  n81_line_monitor hostRx (.clk(clk), .rxd(hostTxd), .bitTime(16'h0a2c));
  n81_line_monitor auxRx (.clk(clk), .rxd(auxTxd), .bitTime(16'h0a2c));

  // Rate code c selects 4800 doubled c times, rounded to whole clocks
  function automatic logic [15:0] expDiv(input int c);
    return 16'((100000000 + (2400 << c)) / (4800 << c));
  endfunction
  task stopTest();
    $display("checks %0d errors %0d", checkCount, errorCnt);
    if (errorCnt == 0 && checkCount > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task powerUp(input logic [1:0] c, input int n);
    @(posedge clk);
    rst_n <= 1'b0;
    baudSelect <= c;
    hostDiffSelect <= c[0];
    auxSingleEndedJumper <= c[1];
    repeat (n) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task pulse(input logic rs);
    @(posedge clk);
    systemResetCmd <= rs;
    portSettingCommand <= !rs;
    @(posedge clk);
    systemResetCmd <= 1'b0;
    portSettingCommand <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  // Valid stays up between words so back-to-back offers never lower and raise it in one step
  task sendHost(input logic [7:0] v);
    hostTxValid <= 1'b1;
    hostTxData <= v;
    hostExp.push_back(v);
    @(negedge clk);
    while (hostTxReady !== 1'b1) @(negedge clk);
    @(posedge clk);
  endtask
  task sendAux(input logic [7:0] v);
    auxTxValid <= 1'b1;
    auxTxData <= v;
    auxExp.push_back(v);
    @(negedge clk);
    while (auxTxReady !== 1'b1) @(negedge clk);
    @(posedge clk);
  endtask

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Three host frames at 38400 take about 78k cycles, set-up adds under two hundred
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 95000)
    begin
      errorCnt++;
      stopTest();
    end
  end

  initial
  begin
    {hostDiffSelect, auxSingleEndedJumper, systemResetCmd, portSettingCommand, portSettingRate} = '0;
    {motion_clear_input, axisCardIds, hostTxValid, hostTxData, auxTxValid, auxTxData} = '0;
    rst_n = 1'b0;
    baudSelect = 2'h1;
    unitIdSwitch = 4'h1;
    powerUp(2'h1, 20);
    `CHK(hostDivisor, expDiv(1))
    `CHK(auxDivisor, expDiv(1))
    `CHK(unitId, 4'h1)
    for (int c = 0; c < 4; c++)
    begin
      powerUp(c[1:0], 2);
      `CHK(hostDivisor, expDiv(c))
      `CHK(hostDiffMode, c[0])
      `CHK(auxDiffMode, !c[1])
      `CHK(unitId, (c == 0) ? 4'h1 : 4'(c + 5))
      @(posedge clk);
      baudSelect <= ~c[1:0];
      hostDiffSelect <= !c[0];
      unitIdSwitch <= 4'(c + 6); // Taken only by the next power-up
      repeat (3) @(posedge clk);
      #1;
      `CHK(hostDivisor, expDiv(c))
    end
    for (int i = 0; i < 6; i++)
    begin
      @(posedge clk);
      d = 8'($random(seed));
      if (i < 2)
        d[3:0] = 4'(i * 10); // Force IDs 0 and 10 so the range flag is seen low
      unitIdSwitch <= d[3:0];
      pulse(1'b1);
      `CHK(unitIdValid, d[3:0] >= 4'h1 && d[3:0] <= 4'h9)
      @(posedge clk);
      unitIdSwitch <= ~d[3:0];
      repeat (2) @(posedge clk);
      #1;
      `CHK(unitId, d[3:0])
    end
    for (int c = 0; c < 4; c++)
    begin
      @(posedge clk);
      portSettingRate <= c[1:0];
      pulse(1'b0);
      `CHK(auxDivisor, expDiv(c))
    end
    for (int i = 0; i < 22; i++)
    begin
      @(posedge clk);
      d = 8'($random(seed));
      motion_clear_input <= d[0];
      if (i < 6)
        axisCardIds <= axisCase[i];
      @(posedge clk);
      #1;
      `CHK(motionEnable, d[0])
      if (i < 6)
        `CHK(axisIdsValid, i < 3)
    end
    // Three quick host words: one sending, two parked, so the buffer must refuse a fourth
    @(posedge clk);
    fork
      begin
        for (int i = 0; i < 3; i++)
          sendHost(8'($random(seed)));
        hostTxValid <= 1'b0;
        @(negedge clk);
        `CHK(hostTxReady, 1'b0)
      end
      begin
        sendAux(8'($random(seed)));
        auxTxValid <= 1'b0;
      end
    join
    wait (hostRx.q.size() == 3 && auxRx.q.size() == 1);
    foreach (hostExp[i])
      `CHK(hostRx.q[i], hostExp[i])
    `CHK(auxRx.q[0], auxExp[0])
    `CHK(hostRx.frameErr + auxRx.frameErr, 0)
    stopTest();
  end
endmodule
